// ### verilog/sec_engine.sv
/*
  Serial EEPROM command engine: a 64 x 16-bit array behind a four-wire
  serial port with self-timed programming and ready/busy status.
  Assumes chip_select, serial_clk and serial_in are synchronous to clk and
  that the pad logic builds the data out wire from its enable.
*/
`timescale 1ns/1ps
// Overview of operation
// - All six address bits select the word for read, write and erase.
// - Other instructions decode from opcode plus the top two address bits.
// - Sixteen data bits follow only for write and fill-all, MSB first.
// - Read loads the word, sends a 0 dummy bit then the word.
// - Reset leaves the device write-disabled until an unlock instruction.
// - Unlock (00, top bits 11) takes effect when select falls.
// - Lock (00, top bits 00) blocks programming when select falls.
// - Reads work whether write-enabled or not.
// - Write and fill-all are accepted only while write-enabled.
// - Fill-all programs every word with the given pattern.
// - Select falling right after D0 starts programming of a write.
// - Erase (11) sets every bit of the addressed word to one.
// - Clear-all (00, top bits 10) sets every word to all ones.
// - Select falling right after A0 starts erase programming.
// - While programming the device is busy and takes no instruction.
// - With select high after programming starts, out shows 0 busy, 1 ready.
// - Out is tri-stated with select low; toggling select spares programming.
// - A start bit after ready returns out to tri-state and may start a command.
// - Leading zeros are ignored; the first one is the start bit.
// - Serial input is sampled on each rising serial clock while selected.
// - A rising select resets the command state machine.
module sec_engine #(
  parameter int WP_CYCLES = sec_pkg::WP_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic data_out,
  output logic data_out_oe_n
);
  localparam int WPW = $clog2(WP_CYCLES + 1);
  localparam int AW = sec_pkg::ADDR_W;
  localparam int DW = sec_pkg::DATA_W;

  // Extended instruction code held in the top two address bits.
  function automatic logic [1:0] ext_of(input logic [AW-1:0] a);
    ext_of = a[AW-1:AW-2];
  endfunction

  // True for instructions that program the array.
  function automatic logic is_prog(input logic [1:0] op, input logic [AW-1:0] a);
    is_prog = (op == sec_pkg::OP_WRITE) || (op == sec_pkg::OP_ERASE) ||
              (op == sec_pkg::OP_EXT && (ext_of(a) == sec_pkg::EXT_FILL ||
                                         ext_of(a) == sec_pkg::EXT_CLEAR));
  endfunction

  logic [DW-1:0] array_reg [sec_pkg::WORDS];
  logic cs_prev_reg, sk_prev_reg;
  logic sk_rise, cs_rise, cs_fall, busy;
  sec_pkg::sec_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] opc_reg, opc_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [DW-1:0] data_reg, data_next, shift_reg, shift_next;
  logic wr_en_reg, wr_en_next, status_reg, status_next, rd_bit_reg, rd_bit_next;
  logic dout_next, doe_n_next;
  logic eng_busy_reg, eng_busy_next, commit;
  logic [sec_pkg::JOB_W-1:0] job_reg, job_next;
  logic [WPW-1:0] wp_cnt_reg, wp_cnt_next;

  sec_stream_if #(.WIDTH(sec_pkg::JOB_W)) job_in ();
  sec_stream_if #(.WIDTH(sec_pkg::JOB_W)) job_out ();

  ////////////////////////////////////////////////////////////////////////
  // Jobs pass through here to the engine; a queued job counts as busy, so the decoder still waits.
  sec_fifo #(.WIDTH(sec_pkg::JOB_W), .DEPTH(sec_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .fill(job_in),
    .drain(job_out)
  );

  // Edge detection on the port lines; only serial clock edges while selected count.
  assign sk_rise = chip_select && serial_clk && !sk_prev_reg;
  assign cs_rise = chip_select && !cs_prev_reg;
  assign cs_fall = !chip_select && cs_prev_reg;
  assign busy = eng_busy_reg || job_out.valid;

  ////////////////////////////////////////////////////////////////////////
  // Command decoder next state.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    opc_next = opc_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    shift_next = shift_reg;
    wr_en_next = wr_en_reg;
    status_next = status_reg;
    rd_bit_next = rd_bit_reg;
    job_in.valid = 1'b0;
    job_in.data = {opc_reg == sec_pkg::OP_EXT, addr_reg,
                   (opc_reg == sec_pkg::OP_ERASE ||
                    ext_of(addr_reg) == sec_pkg::EXT_CLEAR && opc_reg == sec_pkg::OP_EXT)
                   ? sec_pkg::ERASED_WORD : data_reg};
    if (cs_rise) begin
      state_next = sec_pkg::ST_IDLE;
      cnt_next = '0;
    end else if (cs_fall) begin
      // A low select ends the cycle and, once ready, drops the status.
      if (!busy) begin
        status_next = 1'b0;
      end
      if (state_reg == sec_pkg::ST_DONE) begin
        if (opc_reg == sec_pkg::OP_EXT && ext_of(addr_reg) == sec_pkg::EXT_UNLOCK) begin
          wr_en_next = 1'b1;
        end else if (opc_reg == sec_pkg::OP_EXT && ext_of(addr_reg) == sec_pkg::EXT_LOCK) begin
          wr_en_next = 1'b0;
        end else if (is_prog(opc_reg, addr_reg) && wr_en_reg && job_in.ready) begin
          job_in.valid = 1'b1;
          status_next = 1'b1;
        end
      end
      state_next = sec_pkg::ST_IDLE;
    end else if (sk_rise) begin
      case (state_reg)
        sec_pkg::ST_IDLE: begin
          // Zeros before the start bit pass by; busy blocks a new start.
          if (serial_in && !busy) begin
            status_next = 1'b0;
            state_next = sec_pkg::ST_OPC;
            cnt_next = '0;
          end
        end
        sec_pkg::ST_OPC: begin
          opc_next = {opc_reg[0], serial_in};
          cnt_next = (cnt_reg == sec_pkg::OPC_LAST) ? 4'h0 : cnt_reg + 4'h1;
          if (cnt_reg == sec_pkg::OPC_LAST) begin
            state_next = sec_pkg::ST_ADDR;
          end
        end
        sec_pkg::ST_ADDR: begin
          addr_next = {addr_reg[AW-2:0], serial_in};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == sec_pkg::ADDR_LAST) begin
            cnt_next = '0;
            if (opc_reg == sec_pkg::OP_READ) begin
              shift_next = array_reg[addr_next];
              rd_bit_next = 1'b0;
              state_next = sec_pkg::ST_READ;
            end else if (opc_reg == sec_pkg::OP_WRITE ||
                         (opc_reg == sec_pkg::OP_EXT &&
                          ext_of(addr_next) == sec_pkg::EXT_FILL)) begin
              state_next = sec_pkg::ST_DATA;
            end else begin
              state_next = sec_pkg::ST_DONE;
            end
          end
        end
        sec_pkg::ST_DATA: begin
          data_next = {data_reg[DW-2:0], serial_in};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == sec_pkg::DATA_LAST) begin
            state_next = sec_pkg::ST_DONE;
          end
        end
        sec_pkg::ST_READ: begin
          rd_bit_next = shift_reg[DW-1];
          shift_next = {shift_reg[DW-2:0], 1'b0};
        end
        // A clock edge after the last bit means select came too late.
        sec_pkg::ST_DONE: state_next = sec_pkg::ST_SKIP;
        sec_pkg::ST_SKIP: state_next = sec_pkg::ST_SKIP;
        default: state_next = sec_pkg::ST_IDLE;
      endcase
    end
  end

  // Pin drivers; the enable follows select so toggling it is harmless.
  always_comb begin
    doe_n_next = !(chip_select && (state_next == sec_pkg::ST_READ ||
                   (status_next && state_next == sec_pkg::ST_IDLE)));
    dout_next = (state_next == sec_pkg::ST_READ) ? rd_bit_next : !busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // Programming engine: one job at a time, held for the full write time.
  always_comb begin
    eng_busy_next = eng_busy_reg;
    job_next = job_reg;
    wp_cnt_next = wp_cnt_reg;
    commit = 1'b0;
    job_out.ready = !eng_busy_reg;
    if (job_out.valid && !eng_busy_reg) begin
      eng_busy_next = 1'b1;
      job_next = job_out.data;
      wp_cnt_next = '0;
    end else if (eng_busy_reg) begin
      if (wp_cnt_reg == WPW'(WP_CYCLES - 1)) begin
        eng_busy_next = 1'b0;
        commit = 1'b1;
      end else begin
        wp_cnt_next = wp_cnt_reg + 1'b1;
      end
    end
  end

  // Registers; reset stands for power-up, so writes start locked.
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_prev_reg <= 1'b0;
      sk_prev_reg <= 1'b0;
      state_reg <= sec_pkg::ST_IDLE;
      cnt_reg <= '0;
      opc_reg <= '0;
      addr_reg <= '0;
      data_reg <= '0;
      shift_reg <= '0;
      wr_en_reg <= 1'b0;
      status_reg <= 1'b0;
      rd_bit_reg <= 1'b0;
      data_out <= 1'b0;
      data_out_oe_n <= 1'b1;
      eng_busy_reg <= 1'b0;
      job_reg <= '0;
      wp_cnt_reg <= '0;
    end else begin
      cs_prev_reg <= chip_select;
      sk_prev_reg <= serial_clk;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      opc_reg <= opc_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      shift_reg <= shift_next;
      wr_en_reg <= wr_en_next;
      status_reg <= status_next;
      rd_bit_reg <= rd_bit_next;
      data_out <= dout_next;
      data_out_oe_n <= doe_n_next;
      eng_busy_reg <= eng_busy_next;
      job_reg <= job_next;
      wp_cnt_reg <= wp_cnt_next;
    end
  end

  // The array is not reset: its contents outlive power cycles.
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < sec_pkg::WORDS; i++) begin
        if (job_reg[sec_pkg::JOB_W-1] || job_reg[DW +: AW] == AW'(i)) begin
          array_reg[i] <= job_reg[DW-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  property p_tristate;
    @(posedge clk) disable iff (reset) !chip_select |=> data_out_oe_n;
  endproperty
  a_tristate: assert property (p_tristate) else $error("out driven while deselected");

  property p_locked_no_job;
    @(posedge clk) disable iff (reset) job_in.valid |-> wr_en_reg && !busy;
  endproperty
  a_locked_no_job: assert property (p_locked_no_job) else $error("job while locked");

  property p_lock;
    @(posedge clk) disable iff (reset)
      cs_fall && state_reg == sec_pkg::ST_DONE && opc_reg == sec_pkg::OP_EXT &&
      ext_of(addr_reg) == sec_pkg::EXT_LOCK |=> !wr_en_reg ##1 !job_in.valid;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not applied");

  property p_unlock;
    @(posedge clk) disable iff (reset)
      cs_fall && state_reg == sec_pkg::ST_DONE && opc_reg == sec_pkg::OP_EXT &&
      ext_of(addr_reg) == sec_pkg::EXT_UNLOCK |=> wr_en_reg;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not applied");

  property p_powerup_locked;
    @(posedge clk) reset |=> !wr_en_reg;
  endproperty
  a_powerup_locked: assert property (p_powerup_locked) else $error("unlocked at reset");

  property p_busy_status;
    @(posedge clk) disable iff (reset)
      chip_select && state_reg == sec_pkg::ST_IDLE && status_reg && eng_busy_reg
      |=> !data_out_oe_n && !data_out;
  endproperty
  a_busy_status: assert property (p_busy_status) else $error("busy not shown");

  property p_dummy;
    @(posedge clk) disable iff (reset)
      sk_rise && state_reg == sec_pkg::ST_ADDR && cnt_reg == sec_pkg::ADDR_LAST &&
      opc_reg == sec_pkg::OP_READ |=> !data_out_oe_n && !data_out;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy zero");

  property p_start_clears;
    @(posedge clk) disable iff (reset)
      sk_rise && state_reg == sec_pkg::ST_IDLE && serial_in && status_reg && !busy
      |=> !status_reg && state_reg == sec_pkg::ST_OPC && data_out_oe_n;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("status not cleared");

  property p_cs_rise;
    @(posedge clk) disable iff (reset) cs_rise |=> state_reg == sec_pkg::ST_IDLE;
  endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("no restart on select");

  property p_wp_len;
    @(posedge clk) disable iff (reset)
      $fell(eng_busy_reg) |-> $past(wp_cnt_reg) == WPW'(WP_CYCLES - 1);
  endproperty
  a_wp_len: assert property (p_wp_len) else $error("program time wrong");

  c_read: cover property (@(posedge clk) state_reg == sec_pkg::ST_READ);
  c_job: cover property (@(posedge clk) job_in.valid);
  c_commit: cover property (@(posedge clk) commit);
  c_late: cover property (@(posedge clk) state_reg == sec_pkg::ST_SKIP);

endmodule // sec_engine

// ### pkg/sec_pkg.sv
/*
  Shared constants of the serial EEPROM command engine: instruction codes,
  field widths, bit counts and the self-timed programming time.
  Assumes a single 25 MHz system clock drives all of the logic.
*/
package sec_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORDS = 64;
  localparam int JOB_W = 1 + ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 16;

  // Opcode field values.
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  // Top two address bits that pick the extended instruction.
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_CLEAR = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;

  // Last bit index of each serial field.
  localparam logic [3:0] OPC_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h5;
  localparam logic [3:0] DATA_LAST = 4'hF;

  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // Programming time; a longest time, so the cycle count rounds down.
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WP_NS = 10000000;
  localparam int WP_CYCLES = T_WP_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_DONE = 3'b101,
    ST_SKIP = 3'b110
  } sec_state_t;

endpackage

// ### pkg/sec_stream_if.sv
/*
  Valid/ready stream carrying programming jobs between the command decoder
  and the programming engine through the job FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sec_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface // sec_stream_if

// ### verilog/sec_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  sec_stream_if.dst fill,
  sec_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // Full and empty come from pointers with one extra wrap bit.
  assign fill.ready = (wptr_reg[AW] == rptr_reg[AW]) || (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]);
  assign drain.valid = (wptr_reg != rptr_reg);
  assign drain.data = mem_reg[rptr_reg[AW-1:0]];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // Pointer advance.
  always_comb begin
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
  end

  // Storage needs no reset; only the pointers define what is valid.
  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= fill.data;
    end
  end

endmodule // sec_fifo

// ### tb/sec_master_model.sv
/*
  Serial bus master model for the EEPROM command engine: drives select, serial
  clock and data in, and records data out and its enable once per serial bit.
  Assumes a free-running system clock; every pin changes 1 ns after its edge.
*/
`timescale 1ns/1ps
module sec_master_model (
  input wire logic clk,
  output logic chip_select,
  output logic serial_clk,
  output logic serial_in,
  input wire logic data_out,
  input wire logic data_out_oe_n
);
  logic [27:0] dq;
  logic [27:0] oq;

  // A released line has no pull, so it shows the opposite of the current data_out register.
  wire line_seen = data_out_oe_n ? ~data_out : data_out;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus: deselected, with the serial clock parked low between frames.
  initial begin
    chip_select = 1'h0;
    serial_clk = 1'h0;
    serial_in = 1'h0;
    dq = 28'h0;
    oq = 28'h0;
  end

  // One bit; the high phase lasts three cycles, and the reply is recorded two cycles after the rise, once settled.
  task automatic put_bit(input logic b);
    @(posedge clk) #1;
    serial_clk = 1'h0;
    serial_in = b;
    @(posedge clk) #1;
    serial_clk = 1'h1;
    @(posedge clk);
    @(posedge clk) #1;
    dq = {dq[26:0], line_seen};
    oq = {oq[26:0], data_out_oe_n};
  endtask

  // Raising the select restarts the decoder, so a frame already open is left alone.
  task automatic select_on();
    if (chip_select !== 1'h1) begin
      @(posedge clk) #1;
      chip_select = 1'h1;
    end
  endtask

  // Select falls before any further rise; data in is released to a changed level.
  task automatic select_off();
    @(posedge clk) #1;
    chip_select = 1'h0;
    serial_clk = 1'h0;
    serial_in = ~serial_in;
    @(posedge clk);
    @(posedge clk) #1;
  endtask

  // Whole instruction, most significant bit first, closed by dropping the select.
  task automatic instr(input logic [27:0] bits, input int n);
    select_on();
    for (int i = n - 1; i >= 0; i--) begin
      put_bit(bits[i]);
    end
    select_off();
  endtask

  // Status poll without serial clock; the select is left high for the caller.
  task automatic poll(input int max_cycles, output int busy, output logic rdy);
    busy = 0;
    select_on();
    @(posedge clk);
    @(posedge clk) #1;
    while (line_seen !== 1'h1 && busy < max_cycles) begin
      busy++;
      @(posedge clk) #1;
    end
    rdy = line_seen & ~data_out_oe_n;
  endtask
endmodule // sec_master_model

// ### tb/testbench.sv
/*
  Self-checking bench of the serial EEPROM command engine.
  Assumes the master model in sec_master_model and a shortened programming time.
*/
`timescale 1ns/1ps
module testbench;
  localparam int WP = 100;
  logic clk;
  logic reset;
  wire chip_select;
  wire serial_clk;
  wire serial_in;
  wire data_out;
  wire data_out_oe_n;
  int num_errors;
  int n_tests;
  int cycles;

  sec_engine #(.WP_CYCLES(WP)) uut (.clk(clk), .reset(reset), .chip_select(chip_select),
    .serial_clk(serial_clk), .serial_in(serial_in), .data_out(data_out),
    .data_out_oe_n(data_out_oe_n));

  sec_master_model m (.clk(clk), .chip_select(chip_select), .serial_clk(serial_clk),
    .serial_in(serial_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 25 MHz clock.
  initial clk = 1'h0;
  always #20 clk = ~clk;

  // A hang is cut short well past the longest expected run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Extended instructions carry junk in the four low address bits.
  task automatic ext(input logic [1:0] code);
    m.instr({19'h0, 1'h1, sec_pkg::OP_EXT, code, 4'hA}, 9);
  endtask

  task automatic wr(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    m.instr({3'h0, 1'h1, op, a, d}, 25);
  endtask

  // A read yields the dummy zero then the word, driven throughout; idle afterwards.
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    m.instr({3'h0, 1'h1, sec_pkg::OP_READ, a, 16'h0}, 25);
    check("read word", m.dq[16:0], {1'h0, exp});
    check("read enable", m.oq[16:0], 17'h0);
    check("idle enable", data_out_oe_n, 1'h1);
  endtask

  // Programming must show busy for at least min_busy polls, and for no more than two polls past the set time.
  task automatic wait_ready(input int min_busy);
    int busy;
    logic rdy;
    m.poll(WP + 10, busy, rdy);
    check("ready status", rdy, 1'h1);
    check("busy length", busy >= min_busy && busy <= WP + 2, 1'h1);
  endtask

  task automatic no_status();
    m.select_on();
    repeat (2) @(posedge clk);
    #1;
    check("no status enable", data_out_oe_n, 1'h1);
    m.select_off();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_boot_fill();
    ext(sec_pkg::EXT_CLEAR);
    no_status();
    ext(sec_pkg::EXT_UNLOCK);
    wr(sec_pkg::OP_EXT, {sec_pkg::EXT_FILL, 4'h5}, 16'hA5C3);
    wait_ready(WP - 5);
    m.select_off();
    rd(6'h00, 16'hA5C3);
    rd(6'h3F, 16'hA5C3);
  endtask

  // The read's start bit clears the ready status inside the same frame.
  task automatic s_write();
    wr(sec_pkg::OP_WRITE, 6'h00, 16'h8001);
    wait_ready(WP - 5);
    rd(6'h00, 16'h8001);
    check("status cleared", m.oq[24], 1'h1);
    wr(sec_pkg::OP_WRITE, 6'h3F, 16'h7FFE);
    wait_ready(WP - 5);
    m.select_off();
    rd(6'h3F, 16'h7FFE);
    // One serial clock too many after D0 must abort the write: no status, word kept.
    m.instr({2'h0, 1'h1, sec_pkg::OP_WRITE, 6'h15, 16'h5555, 1'h0}, 26);
    no_status();
    rd(6'h15, 16'hA5C3);
  endtask

  // Select toggling and a refused erase while busy must not disturb the write.
  task automatic s_erase_busy();
    m.instr({19'h0, 1'h1, sec_pkg::OP_ERASE, 6'h3F}, 9);
    wait_ready(WP - 5);
    m.select_off();
    rd(6'h3F, sec_pkg::ERASED_WORD);
    wr(sec_pkg::OP_WRITE, 6'h15, 16'h1234);
    m.select_on();
    repeat (2) @(posedge clk);
    #1;
    check("busy status", {data_out, data_out_oe_n}, 2'h0);
    m.select_off();
    check("deselected enable", data_out_oe_n, 1'h1);
    m.instr({19'h0, 1'h1, sec_pkg::OP_ERASE, 6'h00}, 9);
    // Part of the write time is spent on the refused erase, so less busy is left.
    wait_ready(WP / 4);
    m.select_off();
    rd(6'h15, 16'h1234);
    rd(6'h00, 16'h8001);
  endtask

  // Lock after programming; writes are then ignored but reads still work.
  task automatic s_lock();
    ext(sec_pkg::EXT_LOCK);
    wr(sec_pkg::OP_WRITE, 6'h15, 16'h0000);
    no_status();
    rd(6'h15, 16'h1234);
    m.instr({3'h0, 1'h1, sec_pkg::OP_READ, 6'h00, 16'h0}, 28);
    check("zeros read", m.dq[16:0], 17'h08001);
  endtask

  task automatic s_clear();
    ext(sec_pkg::EXT_UNLOCK);
    ext(sec_pkg::EXT_CLEAR);
    wait_ready(WP - 5);
    m.select_off();
    rd(6'h00, sec_pkg::ERASED_WORD);
    rd(6'h15, sec_pkg::ERASED_WORD);
    ext(sec_pkg::EXT_LOCK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: two-cycle reset, then each scenario in turn.
  initial begin
    reset = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'h0;
    s_boot_fill();
    s_write();
    s_erase_busy();
    s_lock();
    s_clear();
    summarize();
  end
endmodule // testbench
